// ===== verilog/iaaf_top.v
// Arbitration-loss and address-recognition flags with Wishbone access
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "iaaf_map.vh"

module iaaf_top (
  input  wire        ref_clk_in,     // 20 MHz block clock
  input  wire        sys_rst_in,     // Synchronous reset, high
  // Wishbone classic slave
  input  wire        wb_cyc_in,      // Bus cycle
  input  wire        wb_stb_in,      // Strobe
  input  wire        wb_we_in,       // Write enable
  input  wire [7:0]  wb_adr_in,      // Byte address
  input  wire [3:0]  wb_sel_in,      // Byte lanes
  input  wire [31:0] wb_dat_in,      // Write data
  output reg  [31:0] wb_dat_out,     // Read data
  output reg         wb_ack_out,     // Acknowledge
  // Bus pins and own drive levels
  input  wire        scl_pin_in,     // Sampled clock line
  input  wire        sda_pin_in,     // Sampled data line
  input  wire        int_scl_in,     // Own internal clock level
  input  wire        int_sda_in,     // Own internal data level
  // Flags and interrupt
  output reg         arbitration_lost_flag_out,  // Loss flag
  output reg         own_address_match_flag_out, // Match flag
  output reg         broadcast_address_flag_out, // Broadcast flag
  output reg         irq_out                     // Level interrupt
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  wire scl_lvl;   // Filtered clock line
  wire scl_rise;  // Clock line rose
  wire scl_fall;  // Clock line fell
  wire sda_lvl;   // Filtered data line
  wire sda_rise;  // Data line rose
  wire sda_fall;  // Data line fell

  iaaf_sync u_scl_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (scl_pin_in),
    .level_out  (scl_lvl),
    .rise_out   (scl_rise),
    .fall_out   (scl_fall)
  );

  iaaf_sync u_sda_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (sda_pin_in),
    .level_out  (sda_lvl),
    .rise_out   (sda_rise),
    .fall_out   (sda_fall)
  );

  // ------------------------------------------------------------
  // Software-visible and internal state
  // ------------------------------------------------------------
  reg [`IAAF_CTRL_W-1:0] ctrl_r;      // Mode and select bits
  reg [6:0]              prim_addr_r; // Primary slave address field
  reg [7:0]              tx_data_r;   // Transfer data, write side
  reg [7:0]              rx_data_r;   // Last completed first frame after start
  reg [`IAAF_ST_W-1:0]   irq_stat_r;  // Sticky event bits
  reg [`IAAF_ST_W-1:0]   irq_en_r;    // Interrupt enables
  reg [`IAAF_ST_W-1:0]   seen_one_r;  // Flag was read as one
  reg                    start_arm_r; // Start issued, not yet driven
  reg [7:0]              shift_r;     // Incoming frame bits
  reg [3:0]              bit_cnt_r;   // Bits of first frame
  reg                    collect_r;   // First frame in progress

  // Mode decode
  wire master_mode   = ctrl_r[`IAAF_CTRL_MASTER];
  wire transmit_mode = ctrl_r[`IAAF_CTRL_TRANSMIT];
  wire arbitration_detect_select = ctrl_r[`IAAF_CTRL_ARB_SEL];
  wire primary_format_select     = ctrl_r[`IAAF_CTRL_PFS];
  wire secondary_format_select   = ctrl_r[`IAAF_CTRL_SFS];
  wire master_tx = master_mode & transmit_mode;
  wire slave_rx  = ~master_mode & ~transmit_mode;

  // ------------------------------------------------------------
  // Bus access decode
  // ------------------------------------------------------------
  // Access taken in the cycle before ack rises
  wire take    = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire wr_lo   = take & wb_we_in & wb_sel_in[0];
  wire rd      = take & ~wb_we_in;
  wire hit_ctl = (wb_adr_in == `IAAF_OFS_CTRL);
  wire hit_adr = (wb_adr_in == `IAAF_OFS_ADDR);
  wire hit_st  = (wb_adr_in == `IAAF_OFS_STATUS);
  wire hit_dat = (wb_adr_in == `IAAF_OFS_DATA);
  wire hit_is  = (wb_adr_in == `IAAF_OFS_IRQ_STAT);
  wire hit_ic  = (wb_adr_in == `IAAF_OFS_IRQ_CLR);
  wire hit_ie  = (wb_adr_in == `IAAF_OFS_IRQ_EN);

  // Data register access clears flags by direction
  wire data_clr = (wr_lo & hit_dat & transmit_mode) |
                  (rd & hit_dat & ~transmit_mode);  // R4

  // Current flags gathered in status layout
  wire [`IAAF_ST_W-1:0] flags = {arbitration_lost_flag_out,
                                 own_address_match_flag_out,
                                 broadcast_address_flag_out,
                                 1'b0};

  // Zero written over a flag that was read as one
  wire [`IAAF_ST_W-1:0] sw_clr =
    {`IAAF_ST_W{wr_lo & hit_st}} & ~wb_dat_in[`IAAF_ST_W-1:0] &
    seen_one_r;  // R5 R10

  // ------------------------------------------------------------
  // Arbitration-loss detection
  // ------------------------------------------------------------
  // Data mismatch sampled at the clock rise
  wire arb_mismatch = master_tx & scl_rise &
                      (int_sda_in != sda_lvl);  // R1
  // Own clock still high when the bus clock falls
  wire arb_clk = master_tx & ~arbitration_detect_select &
                 scl_fall & int_scl_in;  // R2
  // Someone else pulled data low first after start
  wire arb_start = master_tx & arbitration_detect_select &
                   start_arm_r & ~sda_lvl & int_sda_in;  // R3
  wire arb_set = arb_mismatch | arb_clk | arb_start;

  // ------------------------------------------------------------
  // Start, stop and first-frame tracking
  // ------------------------------------------------------------
  wire bus_start = sda_fall & scl_lvl;  // Data falls, clock high
  wire bus_stop  = sda_rise & scl_lvl;  // Data rises, clock high
  wire last_bit  = collect_r & scl_rise &
                   (bit_cnt_r == `IAAF_FRAME_BITS - 4'h1);
  wire [7:0] frame = {shift_r[6:0], sda_lvl};  // Completed frame
  wire frame_zero  = (frame == `IAAF_BCAST_FRAME);
  wire frame_addr  = (frame[7:1] == prim_addr_r);

  // Recognition, only in slave receive mode
  wire match_set = last_bit & slave_rx & ~primary_format_select &
                   (frame_addr |  // R6
                    frame_zero);  // R7 R9
  wire bcast_set = last_bit & slave_rx & frame_zero &
                   (~primary_format_select |
                    ~secondary_format_select);  // R8 R9

  wire [`IAAF_ST_W-1:0] ev = {arb_set, match_set, bcast_set, 1'b0};

  // ------------------------------------------------------------
  // Frame shifter: only the first frame after start matters
  // ------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      shift_r   <= 8'h00;
      bit_cnt_r <= 4'h0;
      collect_r <= 1'b0;
      rx_data_r <= 8'h00;
    end else if (bus_start) begin
      // Restart also covers repeated start
      bit_cnt_r <= 4'h0;
      collect_r <= 1'b1;
    end else if (bus_stop) begin
      collect_r <= 1'b0;
    end else if (collect_r && scl_rise) begin
      shift_r   <= frame;
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (last_bit) begin
        // Frame done; later frames are not looked at here
        collect_r <= 1'b0;
        rx_data_r <= frame;
      end
    end
  end

  // ------------------------------------------------------------
  // Start-command arming for the early-low check
  // ------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      start_arm_r <= 1'b0;
    end else if (wr_lo && hit_ctl && wb_dat_in[`IAAF_CTRL_START]) begin
      start_arm_r <= 1'b1;  // R3
    end else if (~int_sda_in || arb_start || ~master_tx) begin
      // Disarm once we drive low ourselves or loss seen
      start_arm_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Status flags: set wins over every clear
  // ------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      arbitration_lost_flag_out  <= 1'b0;  // R11
      own_address_match_flag_out <= 1'b0;  // R11
      broadcast_address_flag_out <= 1'b0;  // R11
    end else begin
      if (arb_set) begin
        arbitration_lost_flag_out <= 1'b1;
      end else if (data_clr || sw_clr[`IAAF_ST_ARB]) begin
        arbitration_lost_flag_out <= 1'b0;  // R4 R5
      end
      if (match_set) begin
        own_address_match_flag_out <= 1'b1;
      end else if (data_clr || sw_clr[`IAAF_ST_MATCH]) begin
        own_address_match_flag_out <= 1'b0;  // R4 R5
      end
      if (bcast_set) begin
        broadcast_address_flag_out <= 1'b1;
      end else if (data_clr || sw_clr[`IAAF_ST_BCAST]) begin
        broadcast_address_flag_out <= 1'b0;  // R4 R5
      end
    end
  end

  // ------------------------------------------------------------
  // Read-as-one memory for the two-step clear
  // ------------------------------------------------------------
  // A zero write without a prior read of one must not clear
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      seen_one_r <= `IAAF_FLAGS_RST;
    end else if (rd && hit_st) begin
      seen_one_r <= flags;  // R5
    end else if (wr_lo && hit_st) begin
      seen_one_r <= `IAAF_FLAGS_RST;  // One read, one clear
    end else begin
      seen_one_r <= seen_one_r & flags;  // Drop bits cleared otherwise
    end
  end

  // ------------------------------------------------------------
  // Control, address, data and interrupt registers
  // ------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ctrl_r      <= `IAAF_CTRL_RST;
      prim_addr_r <= `IAAF_ADDR_RST;
      tx_data_r   <= 8'h00;
      irq_en_r    <= `IAAF_IRQ_RST;
    end else if (wr_lo) begin
      if (hit_ctl) begin
        // Start bit is a command, never stored
        ctrl_r <= wb_dat_in[`IAAF_CTRL_W-1:0] &
                  ~(6'h01 << `IAAF_CTRL_START);
      end
      if (hit_adr) begin
        prim_addr_r <= wb_dat_in[6:0];
      end
      if (hit_dat) begin
        tx_data_r <= wb_dat_in[7:0];
      end
      if (hit_ie) begin
        irq_en_r <= wb_dat_in[`IAAF_ST_W-1:0] &
                    ~(4'h1);  // Bit 0 unused
      end
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_stat_r <= `IAAF_IRQ_RST;
    end else if (wr_lo && hit_ic) begin
      irq_stat_r <= (irq_stat_r & ~wb_dat_in[`IAAF_ST_W-1:0]) | ev;
    end else begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end

  // Level interrupt, one cycle behind the status bits
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_r & irq_en_r);
    end
  end

  // ------------------------------------------------------------
  // Wishbone answer: one registered ack, a cycle after the request
  // ------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= take;
      if (rd) begin
        case (wb_adr_in)
          `IAAF_OFS_CTRL: begin
            wb_dat_out <= {26'h0000000, ctrl_r};
          end
          `IAAF_OFS_ADDR: begin
            wb_dat_out <= {25'h0000000, prim_addr_r};
          end
          `IAAF_OFS_STATUS: begin
            wb_dat_out <= {28'h0000000, flags};
          end
          `IAAF_OFS_DATA: begin
            // Receive side shows the captured frame
            wb_dat_out <= {24'h000000,
                           transmit_mode ? tx_data_r : rx_data_r};
          end
          `IAAF_OFS_IRQ_STAT: begin
            wb_dat_out <= {28'h0000000, irq_stat_r};
          end
          `IAAF_OFS_IRQ_EN: begin
            wb_dat_out <= {28'h0000000, irq_en_r};
          end
          default: begin
            // Unmapped and write-only read as zero
            wb_dat_out <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule // iaaf_top

`default_nettype wire

// ===== verilog/iaaf_map.vh
// Register map, field positions and reset values of the flag block
// How it works
// R1: Transmit master: data mismatch at clock rise flags loss
// R2: Select 0: own clock high at bus fall flags loss
// R3: Select 1: foreign low after start command flags loss
// R4: Data access by direction clears all three flags
// R5: Flag clears on zero write after reading one
// R6: Slave receive, format 0: address match sets flag
// R7: Slave receive, format 0: all-zero frame sets match
// R8: All-zero first frame sets broadcast if either format 0
// R9: Primary format 1, secondary 0: broadcast only, no match
// R10: Written one leaves flags unchanged
// R11: All three flags zero after reset
`ifndef IAAF_MAP_VH
`define IAAF_MAP_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define IAAF_OFS_CTRL      8'h00
`define IAAF_OFS_ADDR      8'h04
`define IAAF_OFS_STATUS    8'h08
`define IAAF_OFS_DATA      8'h0c
`define IAAF_OFS_IRQ_STAT  8'h10
`define IAAF_OFS_IRQ_CLR   8'h14
`define IAAF_OFS_IRQ_EN    8'h18

// ------------------------------------------------------------
// Control register bit positions
// ------------------------------------------------------------
`define IAAF_CTRL_MASTER   0
`define IAAF_CTRL_TRANSMIT 1
`define IAAF_CTRL_ARB_SEL  2
`define IAAF_CTRL_START    3
`define IAAF_CTRL_PFS      4
`define IAAF_CTRL_SFS      5
`define IAAF_CTRL_W        6

// ------------------------------------------------------------
// Status flag positions (same layout in irq registers)
// ------------------------------------------------------------
`define IAAF_ST_BCAST      1
`define IAAF_ST_MATCH      2
`define IAAF_ST_ARB        3
`define IAAF_ST_W          4

// ------------------------------------------------------------
// Reset values and frame constants
// ------------------------------------------------------------
`define IAAF_CTRL_RST      6'h00
`define IAAF_ADDR_RST      7'h00
`define IAAF_FLAGS_RST     4'h0
`define IAAF_IRQ_RST       4'h0
`define IAAF_BCAST_FRAME   8'h00
`define IAAF_FRAME_BITS    4'h8

`endif

// ===== verilog/iaaf_sync.v
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
`default_nettype none

module iaaf_sync (
  input  wire ref_clk_in,  // Block clock
  input  wire sys_rst_in,  // Synchronous reset, high
  input  wire pin_in,      // Asynchronous pin level
  output reg  level_out,   // Filtered level
  output reg  rise_out,    // One-cycle pulse on rise
  output reg  fall_out     // One-cycle pulse on fall
);

  reg meta_r;   // First stage, read by second only
  reg sync2_r;  // Second stage
  reg sync3_r;  // Third stage

  // ------------------------------------------------------------
  // Shift chain and filtered level
  // ------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      meta_r    <= 1'b1;
      sync2_r   <= 1'b1;
      sync3_r   <= 1'b1;
      level_out <= 1'b1;  // Idle bus is high
      rise_out  <= 1'b0;
      fall_out  <= 1'b0;
    end else begin
      meta_r   <= pin_in;
      sync2_r  <= meta_r;
      sync3_r  <= sync2_r;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
      // A change counts only once stages two and three agree
      if ((sync2_r == sync3_r) && (sync3_r != level_out)) begin
        level_out <= sync3_r;
        rise_out  <= sync3_r;
        fall_out  <= ~sync3_r;
      end
    end
  end

endmodule // iaaf_sync

`default_nettype wire

// ===== sim/iaaf_sva.sv
// Concurrent checks on the flag block top ports
`timescale 1ns/100ps
`default_nettype none
module iaaf_sva (
  input wire logic        ref_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic        wb_ack_out,
  input wire logic        arbitration_lost_flag_out,
  input wire logic        own_address_match_flag_out,
  input wire logic        broadcast_address_flag_out
);
  // ------------------------------------------------
  // Helper logic
  // ------------------------------------------------
  logic       lost;   // Loss flag
  logic       am;     // Match flag
  logic       ab;     // Broadcast flag
  logic       tk;     // Request taken at this edge
  logic       cw;     // Taken write on lane 0
  logic       fclr;   // Taken access that may clear a flag
  logic       dclr;   // Data access that must clear
  logic [5:0] ctl_r;  // Shadow of the mode bits
  assign lost = arbitration_lost_flag_out;
  assign am = own_address_match_flag_out;
  assign ab = broadcast_address_flag_out;
  assign tk = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign cw = tk && wb_we_in && wb_sel_in[0];
  assign fclr = tk && (wb_adr_in == 8'h08 || wb_adr_in == 8'h0c);
  // Write in transmit mode, read in receive mode
  assign dclr = tk && wb_adr_in == 8'h0c && wb_we_in == ctl_r[1]
                && (!wb_we_in || wb_sel_in[0]);
  // Mode shadow; the start bit is a pulse, so it is masked off
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ctl_r <= 6'h00;
    end else if (cw && wb_adr_in == 8'h00) begin
      ctl_r <= wb_dat_in[5:0] & 6'h37;
    end
  end
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  default clocking dc @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_ack_pulse;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  sequence s_all_clear;
    !lost && !am && !ab;
  endsequence
  a_ack_one_pulse: assert property (tk |=> s_ack_pulse)
    else $error("ack is not a single pulse");
  a_flags_reset_zero: assert property ($fell(sys_rst_in) |-> s_all_clear)
    else $error("flag set after reset");
  a_arb_needs_mode: assert property ($rose(lost) |-> ctl_r[1:0] == 2'b11)
    else $error("loss flag outside master transmit");
  a_match_needs_mode: assert property ($rose(am) |-> ctl_r[1:0] == 2'b00 && !ctl_r[4])
    else $error("match flag in wrong mode or format");
  a_bcast_needs_fmt: assert property ($rose(ab) |-> ctl_r[1:0] == 2'b00 && !(ctl_r[4] && ctl_r[5]))
    else $error("broadcast flag in wrong mode or format");
  a_one_keeps_flag: assert property (cw && wb_adr_in == 8'h08 && wb_dat_in[3] && lost |=> lost)
    else $error("written one cleared the loss flag");
  a_clear_has_cause: assert property (($fell(lost) || $fell(am) || $fell(ab)) && !$past(sys_rst_in) |-> $past(fclr))
    else $error("flag cleared without an access");
  a_data_clears: assert property (dclr |=> s_all_clear)
    else $error("data access left a flag set");
endmodule // iaaf_sva
`default_nettype wire

// ===== sim/iaaf_peer.sv
// Model of the other masters and slaves on the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module iaaf_peer (
  output var logic scl_out,  // Peer clock drive, 1 means released
  output var logic sda_out   // Peer data drive, 1 means released
);
  localparam int HALF = 200;  // Half of the 400 ns link period
  localparam int LEAD = 50;   // Data moves well clear of clock edges
  // Released lines sit high through the pull-up
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Hold both lines at given levels
  task automatic pull(input logic c, input logic d);
    begin
      scl_out <= c;
      sda_out <= d;
    end
  endtask
  // Start, one frame MSB first, stop; clock stands still after
  task automatic frame(input logic [7:0] b);
    begin
      sda_out <= 1'b0;
      #HALF scl_out <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
        #LEAD sda_out <= b[i];
        #(HALF - LEAD) scl_out <= 1'b1;
        #HALF scl_out <= 1'b0;
      end
      #LEAD sda_out <= 1'b0;
      #(HALF - LEAD) scl_out <= 1'b1;
      #HALF sda_out <= 1'b1;
      #HALF;
    end
  endtask
endmodule // iaaf_peer
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the arbitration and address flag block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;     // 20 MHz block clock
  logic        rst = 1'b1;     // Synchronous reset
  logic        cyc = 1'b0;     // Bus cycle
  logic        stb = 1'b0;     // Strobe
  logic        we = 1'b0;      // Write enable
  logic [7:0]  adr = 8'h00;    // Byte address
  logic [3:0]  sel = 4'hf;     // Lanes
  logic [31:0] wd = 32'h0;     // Write data
  logic        iscl = 1'b1;    // Own clock level
  logic        isda = 1'b1;    // Own data level, kept released
  wire  [31:0] rd;             // Read data
  wire         ack, irq;       // Acknowledge, interrupt
  wire         pscl, psda;     // Peer drives
  wire         lost, am, ab;   // Flags
  wire         scl = iscl & pscl;  // Wired-AND lines with pull-up
  wire         sda = isda & psda;
  int          num_errors = 0; // Mismatches
  int          checked = 0;    // Comparisons
  logic        e_lost = 1'b0;  // Model flags
  logic        e_am = 1'b0;
  logic        e_ab = 1'b0;
  logic [7:0]  frames[$];      // First frames to send
  always #25 clk = ~clk;
  iaaf_top u_dut (.ref_clk_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wd), .wb_dat_out(rd), .wb_ack_out(ack), .scl_pin_in(scl),
    .sda_pin_in(sda), .int_scl_in(iscl), .int_sda_in(isda),
    .arbitration_lost_flag_out(lost), .own_address_match_flag_out(am),
    .broadcast_address_flag_out(ab), .irq_out(irq));
  iaaf_peer u_peer (.scl_out(pscl), .sda_out(psda));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Classic cycle: hold until ack, then idle one cycle
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (n >= 16) begin
      num_errors++;
    end
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic gap;
    repeat (12) @(posedge clk);
  endtask
  // Status register and flag pins against the model
  task automatic flags;
    logic [31:0] q;
    bus(1'b0, 8'h08, 32'h0, q);
    chk(q, {28'h0, e_lost, e_am, e_ab, 1'b0});
    chk({29'h0, lost, am, ab}, {29'h0, e_lost, e_am, e_ab});
  endtask
  task automatic end_of_test;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog well past the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    end_of_test;
  end
  initial begin
    logic [31:0] q;
    logic [31:0] r;
    logic [6:0]  own;
    void'($urandom(32'h6ec2));
    r = $urandom;
    own = r[6:0] | 7'h01;
    frames = '{{own, r[7]}, 8'h00, {own ^ 7'h01, 1'b1}};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    flags();
    bus(1'b0, 8'hfc, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b1, 8'h04, {25'h0, own}, q);
    bus(1'b1, 8'h18, 32'h0e, q);
    // Slave receive: every format pair against every frame kind
    for (int c = 0; c < 4; c++) begin
      foreach (frames[k]) begin
        bus(1'b1, 8'h00, {26'h0, c[1:0], 4'h0}, q);
        u_peer.frame(frames[k]);
        @(posedge clk);
        gap();
        e_am = !c[0] && (frames[k][7:1] == own || frames[k] == 8'h00);
        e_ab = frames[k] == 8'h00 && !(c[0] && c[1]);
        flags();
        if (c == 0 && k == 0) begin
          chk({31'h0, irq}, 32'h1);
          bus(1'b1, 8'h08, 32'h0e, q);
          chk({31'h0, am}, 32'h1);
          bus(1'b1, 8'h08, 32'h0, q);
          chk({31'h0, am}, 32'h1);
          flags();
          bus(1'b1, 8'h08, 32'h0, q);
          e_am = 1'b0;
          flags();
          bus(1'b1, 8'h18, 32'h0, q);
          chk({31'h0, irq}, 32'h0);
          bus(1'b1, 8'h18, 32'h0e, q);
          chk({31'h0, irq}, 32'h1);
          bus(1'b1, 8'h14, 32'h0e, q);
          chk({31'h0, irq}, 32'h0);
          bus(1'b0, 8'h10, 32'h0, q);
          chk(q, 32'h0);
        end
        bus(1'b0, 8'h0c, 32'h0, q);
        e_am = 1'b0;
        e_ab = 1'b0;
        flags();
      end
    end
    // Master transmit: three loss cases under both selects
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 3; m++) begin
        // Leaving master transmit drops start arming left from before
        bus(1'b1, 8'h00, 32'h0, q);
        bus(1'b1, 8'h00, {29'h0, s[0], 2'b11}, q);
        case (m)
          0: begin
            iscl <= 1'b0;
            gap();
            u_peer.pull(1'b1, 1'b0);
            gap();
            iscl <= 1'b1;
            gap();
            e_lost = 1'b1;
          end
          1: begin
            u_peer.pull(1'b0, 1'b1);
            gap();
            e_lost = s == 0;
          end
          default: begin
            bus(1'b1, 8'h00, {28'h0, 1'b1, s[0], 2'b11}, q);
            u_peer.pull(1'b1, 1'b0);
            gap();
            e_lost = s == 1;
          end
        endcase
        u_peer.pull(1'b1, 1'b1);
        gap();
        flags();
        // Ones written over a set loss flag must leave it standing
        bus(1'b1, 8'h08, 32'h0e, q);
        chk({31'h0, lost}, {31'h0, e_lost});
        bus(1'b1, 8'h0c, 32'h5a, q);
        e_lost = 1'b0;
        flags();
      end
    end
    end_of_test;
  end
endmodule // testbench
bind iaaf_top iaaf_sva u_sva (.ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out),
  .arbitration_lost_flag_out(arbitration_lost_flag_out),
  .own_address_match_flag_out(own_address_match_flag_out),
  .broadcast_address_flag_out(broadcast_address_flag_out));
`default_nettype wire
